/* File: aas_cfg.svh */
// Purpose: Constants for the 16-bit add, subtract and accumulate datapath
// Assumes: Included by bare name from the sign extension and top design files
// Notes: Definitions only
//
// What this block does
// - Mode select picks A+B, A-B, -A+B or A plus output register.
// - Undriven mode select reads high, giving plain A plus B.
// - Carry out of bit 15 chains into next unit's carry in.
// - Overflow flag goes high when the signed result leaves 16 bits.
// - Overflow flag is combinational from the adder, never registered.
// - Operand words of 10, 12, 14 or 16 bits get sign extended.
// - Width select 00=10, 01=12, 10=14, 11=16 bits (hi,lo order).
// - One width select serves both operands alike.
// - Undriven width select reads high, giving full 16-bit operands.
// - Low input pass control makes operand registers transparent.
// - Low result pass control makes the output register transparent.
// - Register contents are undefined after a transparent spell.
// - Each operand register has its own low-active load enable.
// - A high load enable holds that operand register unchanged.
// - Low bus drive control drives result lines, high floats them.
// - Low clear control zeroes the output register.
// - All registers use the rising edge of the one clock.

`ifndef AAS_CFG_SVH
`define AAS_CFG_SVH

`define AAS_W 16
`define AAS_MSB 15
`define AAS_CARRY_BIT 16
`define AAS_ZERO 16'h0000
`define AAS_SIGN_10 9
`define AAS_SIGN_12 11
`define AAS_SIGN_14 13
`define AAS_SIGN_16 15

`endif

/* File: aas_pkg.sv */
// Purpose: Types for the add, subtract and accumulate datapath
// Assumes: Order of select bits is {hi, lo}
// Notes: All-ones codes are the pulled-up defaults

`default_nettype none

package aas_pkg;

	// Operation, index {op_sel_hi, op_sel_lo}
	typedef enum logic [1:0] {
		AAS_OP_ACC = 2'b00,
		AAS_OP_A_MINUS_B = 2'b01,
		AAS_OP_B_MINUS_A = 2'b10,
		AAS_OP_A_PLUS_B = 2'b11
	} aas_op_t;

	// Operand length, index {width_sel_hi, width_sel_lo}
	typedef enum logic [1:0] {
		AAS_WID_10 = 2'b00,
		AAS_WID_12 = 2'b01,
		AAS_WID_14 = 2'b10,
		AAS_WID_16 = 2'b11
	} aas_width_t;

endpackage : aas_pkg

`default_nettype wire

/* File: aas_sext.sv */
// Purpose: Sign extension of one operand word
// Assumes: Purely combinational
// Notes: Instantiated once per operand

`include "aas_cfg.svh"

`default_nettype none

module aas_sext
	import aas_pkg::*;
(
	input wire logic [`AAS_MSB:0] i_word,
	input wire logic [1:0] i_width_sel,
	output logic [`AAS_MSB:0] o_word
);

	wire aas_width_t width_sel = aas_width_t'(i_width_sel);
	wire logic [`AAS_MSB:0] ext_10;
	wire logic [`AAS_MSB:0] ext_12;
	wire logic [`AAS_MSB:0] ext_14;

	// Copy the chosen sign bit into all higher positions
	assign ext_10 = {{(`AAS_MSB - `AAS_SIGN_10){i_word[`AAS_SIGN_10]}},
		i_word[`AAS_SIGN_10:0]};
	assign ext_12 = {{(`AAS_MSB - `AAS_SIGN_12){i_word[`AAS_SIGN_12]}},
		i_word[`AAS_SIGN_12:0]};
	assign ext_14 = {{(`AAS_MSB - `AAS_SIGN_14){i_word[`AAS_SIGN_14]}},
		i_word[`AAS_SIGN_14:0]};

	// All-ones code, the pulled-up default, passes the word unchanged
	assign o_word = (width_sel == AAS_WID_10) ? ext_10 :
		(width_sel == AAS_WID_12) ? ext_12 :
		(width_sel == AAS_WID_14) ? ext_14 : i_word;

endmodule : aas_sext

`default_nettype wire

/* File: aas_top.sv */
// Purpose: 16-bit two's-complement add, subtract and accumulate datapath
// Assumes: Operands and controls come from logic on I_CORE_CLK
// Notes: Carry, overflow and transparent result are combinational

`include "aas_cfg.svh"

`default_nettype none

module aas_top
	import aas_pkg::*;
(
	input wire logic I_CORE_CLK,
	input wire logic I_RST,
	input wire logic I_CE,
	input wire logic [`AAS_MSB:0] I_FIRST_OPERAND,
	input wire logic [`AAS_MSB:0] I_SECOND_OPERAND,
	input wire logic I_CARRY_IN,
	input wire logic I_OP_SEL_LO,
	input wire logic I_OP_SEL_HI,
	input wire logic I_WIDTH_SEL_LO,
	input wire logic I_WIDTH_SEL_HI,
	input wire logic I_OPERAND_PASS_N,
	input wire logic I_RESULT_PASS_N,
	input wire logic I_LOAD_FIRST_N,
	input wire logic I_LOAD_SECOND_N,
	input wire logic I_RESULT_ZERO_N,
	input wire logic I_BUS_DRIVE_N,
	output logic [`AAS_MSB:0] O_RESULT_BUS,
	output logic O_RESULT_BUS_OE,
	output logic O_CARRY_OUT,
	output logic O_OVERFLOW_FLAG
);

	// ****************************************************************
	// Control decode
	// ****************************************************************

	wire aas_op_t op_sel;
	wire logic [1:0] width_sel;

	// Undriven pins read high, so all-ones means add and full width
	assign op_sel = aas_op_t'({I_OP_SEL_HI, I_OP_SEL_LO});
	assign width_sel = {I_WIDTH_SEL_HI, I_WIDTH_SEL_LO};

	wire logic op_is_acc;
	wire logic inv_first;
	wire logic inv_second;

	assign op_is_acc = (op_sel == AAS_OP_ACC);
	assign inv_first = (op_sel == AAS_OP_B_MINUS_A);
	assign inv_second = (op_sel == AAS_OP_A_MINUS_B);

	// ****************************************************************
	// Sign extension of both operands
	// ****************************************************************

	logic [`AAS_MSB:0] first_ext;
	logic [`AAS_MSB:0] second_ext;

	// Same width select feeds both
	aas_sext u_sext_first (
		.i_word(I_FIRST_OPERAND),
		.i_width_sel(width_sel),
		.o_word(first_ext)
	);

	aas_sext u_sext_second (
		.i_word(I_SECOND_OPERAND),
		.i_width_sel(width_sel),
		.o_word(second_ext)
	);

	// ****************************************************************
	// Operand registers
	// ****************************************************************

	logic [`AAS_MSB:0] first_reg;
	logic [`AAS_MSB:0] first_next;
	logic [`AAS_MSB:0] second_reg;
	logic [`AAS_MSB:0] second_next;

	// Hold while load enable is high, capture while low
	assign first_next = I_LOAD_FIRST_N ? first_reg : first_ext;
	assign second_next = I_LOAD_SECOND_N ? second_reg
		: second_ext;

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			first_reg <= `AAS_ZERO;
			second_reg <= `AAS_ZERO;
		end else if (I_CE) begin
			first_reg <= first_next;
			second_reg <= second_next;
		end
	end

	// Transparent operands bypass the registers; the registers keep
	// loading meanwhile, so their contents carry no promise afterwards
	wire logic [`AAS_MSB:0] op_first;
	wire logic [`AAS_MSB:0] op_second;

	assign op_first = I_OPERAND_PASS_N ? first_reg : first_ext;
	assign op_second = I_OPERAND_PASS_N ? second_reg
		: second_ext;

	// ****************************************************************
	// Adder
	// ****************************************************************

	logic [`AAS_MSB:0] result_reg;
	logic [`AAS_MSB:0] result_next;

	wire logic [`AAS_MSB:0] add_x;
	wire logic [`AAS_MSB:0] add_y;
	wire logic [`AAS_CARRY_BIT:0] add_sum;

	// Subtract by inversion plus the external carry; no inner carry
	assign add_x = inv_first ? ~op_first : op_first;
	assign add_y = op_is_acc ? result_reg
		: (inv_second ? ~op_second : op_second);
	assign add_sum = {1'b0, add_x} + {1'b0, add_y}
		+ {{`AAS_CARRY_BIT{1'b0}}, I_CARRY_IN};

	// Ripple chain: bit 16 feeds the next unit's carry in
	assign O_CARRY_OUT = add_sum[`AAS_CARRY_BIT];

	// Both addends same sign, sum sign differs
	assign O_OVERFLOW_FLAG = (add_x[`AAS_MSB] == add_y[`AAS_MSB])
		&& (add_sum[`AAS_MSB] != add_x[`AAS_MSB]);

	// ****************************************************************
	// Output register and bus
	// ****************************************************************

	// Loads every edge with I_CE high, clear wins
	assign result_next = I_RESULT_ZERO_N ? add_sum[`AAS_MSB:0]
		: `AAS_ZERO;

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			result_reg <= `AAS_ZERO;
		end else if (I_CE) begin
			result_reg <= result_next;
		end
	end

	// Accumulate keeps feeding back the register, avoiding a loop
	assign O_RESULT_BUS = I_RESULT_PASS_N ? result_reg
		: add_sum[`AAS_MSB:0];
	assign O_RESULT_BUS_OE = ~I_BUS_DRIVE_N;

	// ****************************************************************
	// Checks
	// ****************************************************************

	wire logic [`AAS_CARRY_BIT:0] chk_wide;

	assign chk_wide = {add_x[`AAS_MSB], add_x} + {add_y[`AAS_MSB], add_y}
		+ {{`AAS_CARRY_BIT{1'b0}}, I_CARRY_IN};

	AST_ADD: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(op_sel == AAS_OP_A_PLUS_B && !I_OPERAND_PASS_N)
		|-> {O_CARRY_OUT, add_sum[`AAS_MSB:0]} == {1'b0, first_ext}
			+ {1'b0, second_ext} + {{`AAS_CARRY_BIT{1'b0}}, I_CARRY_IN})
	else $error("add mode sum wrong");

	AST_REG_ADD: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(op_sel == AAS_OP_A_PLUS_B && I_OPERAND_PASS_N)
		|-> {O_CARRY_OUT, add_sum[`AAS_MSB:0]} == {1'b0, first_reg}
			+ {1'b0, second_reg} + {{`AAS_CARRY_BIT{1'b0}}, I_CARRY_IN})
	else $error("registered operands not used in add mode");

	AST_SUB: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(op_sel == AAS_OP_A_MINUS_B && I_CARRY_IN)
		|-> add_sum[`AAS_MSB:0] == op_first - op_second)
	else $error("subtract mode difference wrong");

	AST_BORROW: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(op_sel == AAS_OP_A_MINUS_B && I_CARRY_IN)
		|-> O_CARRY_OUT == (op_first >= op_second))
	else $error("carry out wrong in subtract mode");

	AST_NEG_A: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(op_sel == AAS_OP_B_MINUS_A && I_CARRY_IN)
		|-> add_sum[`AAS_MSB:0] == op_second - op_first)
	else $error("negate A mode difference wrong");

	AST_NEG_CARRY: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(op_sel == AAS_OP_B_MINUS_A && I_CARRY_IN)
		|-> O_CARRY_OUT == (op_second >= op_first))
	else $error("carry out wrong in negate A mode");

	AST_ACC: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(I_CE && I_RESULT_ZERO_N && op_is_acc && !I_CARRY_IN)
		|=> result_reg == $past(op_first) + $past(result_reg))
	else $error("accumulate did not add output register");

	AST_OVF: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		O_OVERFLOW_FLAG == (chk_wide[`AAS_CARRY_BIT]
			!= chk_wide[`AAS_MSB]))
	else $error("overflow flag disagrees with signed sum");

	AST_SEXT10: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(width_sel == AAS_WID_10)
		|-> (first_ext[`AAS_MSB:`AAS_SIGN_10]
			== {(`AAS_MSB - `AAS_SIGN_10 + 1){I_FIRST_OPERAND[`AAS_SIGN_10]}})
			&& (second_ext[`AAS_MSB:`AAS_SIGN_10]
			== {(`AAS_MSB - `AAS_SIGN_10 + 1){I_SECOND_OPERAND[`AAS_SIGN_10]}})
			&& (second_ext[`AAS_SIGN_10:0]
			== I_SECOND_OPERAND[`AAS_SIGN_10:0]))
	else $error("ten bit sign extension wrong");

	AST_SEXT12: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(width_sel == AAS_WID_12)
		|-> (first_ext[`AAS_MSB:`AAS_SIGN_12]
			== {(`AAS_MSB - `AAS_SIGN_12 + 1){I_FIRST_OPERAND[`AAS_SIGN_12]}})
			&& (second_ext[`AAS_MSB:`AAS_SIGN_12]
			== {(`AAS_MSB - `AAS_SIGN_12 + 1){I_SECOND_OPERAND[`AAS_SIGN_12]}}))
	else $error("twelve bit sign extension wrong");

	AST_SEXT14: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(width_sel == AAS_WID_14)
		|-> (first_ext[`AAS_MSB:`AAS_SIGN_14]
			== {(`AAS_MSB - `AAS_SIGN_14 + 1){I_FIRST_OPERAND[`AAS_SIGN_14]}})
			&& (second_ext[`AAS_MSB:`AAS_SIGN_14]
			== {(`AAS_MSB - `AAS_SIGN_14 + 1){I_SECOND_OPERAND[`AAS_SIGN_14]}}))
	else $error("fourteen bit sign extension wrong");

	AST_SEXT16: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(width_sel == AAS_WID_16)
		|-> (first_ext == I_FIRST_OPERAND)
			&& (second_ext == I_SECOND_OPERAND))
	else $error("full width operands were altered");

	// ****************************************************************
	// Register and result bus checks
	// ****************************************************************

	AST_HOLD_FIRST: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(I_LOAD_FIRST_N [*2]) |-> $stable(first_reg))
	else $error("first operand register changed while disabled");

	AST_LOAD_SECOND: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(I_CE && !I_LOAD_SECOND_N) |=> second_reg == $past(second_ext))
	else $error("second operand register missed a load");

	AST_LOAD_FIRST: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(I_CE && !I_LOAD_FIRST_N) |=> first_reg == $past(first_ext))
	else $error("first operand register missed a load");

	AST_HOLD_SECOND: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(I_LOAD_SECOND_N [*2]) |-> $stable(second_reg))
	else $error("second operand register changed while disabled");

	AST_CLEAR: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(I_CE && !I_RESULT_ZERO_N) ##1 I_RESULT_PASS_N
		|-> O_RESULT_BUS == `AAS_ZERO)
	else $error("clear did not zero the output register");

	AST_CLEAR_WINS: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(I_CE && !I_RESULT_ZERO_N) |=> result_reg == `AAS_ZERO)
	else $error("clear did not win over the sum");

	AST_OUT_LOAD: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		(I_CE && I_RESULT_ZERO_N) |=> result_reg == $past(add_sum[`AAS_MSB:0]))
	else $error("output register did not load the sum");

	AST_PASS: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		!I_RESULT_PASS_N |-> O_RESULT_BUS == add_sum[`AAS_MSB:0])
	else $error("transparent output does not show the sum");

	AST_DRIVE: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		O_RESULT_BUS_OE == !I_BUS_DRIVE_N)
	else $error("result bus enable wrong");

	AST_FREEZE: assert property (
		@(posedge I_CORE_CLK) disable iff (I_RST)
		!I_CE |=> $stable(result_reg) && $stable(first_reg)
			&& $stable(second_reg))
	else $error("state changed with clock enable low");

	AST_RESET: assert property (
		@(posedge I_CORE_CLK)
		I_RST |=> (result_reg == `AAS_ZERO) && (first_reg == `AAS_ZERO)
			&& (second_reg == `AAS_ZERO))
	else $error("reset did not clear the registers");

endmodule : aas_top

`default_nettype wire

/* File: aas_carry_src.sv */
// Purpose: Outside logic that sets the carry in for the chosen mode
// Assumes: Mode select order is {hi, lo}
// Notes: Subtract modes need a carry of one, add and accumulate zero

`default_nettype none

module aas_carry_src (
	input wire logic i_op_sel_lo,
	input wire logic i_op_sel_hi,
	output logic o_carry_in
);
	timeunit 1ns;
	timeprecision 1ps;
	assign o_carry_in = i_op_sel_lo ^ i_op_sel_hi;
endmodule : aas_carry_src

`default_nettype wire

/* File: aas_top_bench.sv */
// Purpose: Self-checking bench for the add, subtract, accumulate block
// Assumes: Inputs change at the falling edge only
// Notes: Result bus is resolved to Z while the block floats it

`default_nettype none

module aas_top_bench;
	import aas_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Stimulus and wiring
	// ****************************************
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic opn = 1'b1;
	logic rpn = 1'b1;
	logic lan = 1'b1;
	logic lbn = 1'b1;
	logic zn = 1'b1;
	logic bdn = 1'b0;
	logic [1:0] op = 2'b11;
	logic [1:0] wd = 2'b11;
	logic [15:0] a = 16'h0000;
	logic [15:0] b = 16'h0000;
	wire cin;
	wire oe;
	wire co;
	wire ov;
	wire [15:0] bus;
	wire [15:0] f_line;
	int err_count = 0;
	int checks = 0;
	assign f_line = oe ? bus : 16'hzzzz;
	always #5 clk = ~clk;
	aas_carry_src u_src (.i_op_sel_lo(op[0]), .i_op_sel_hi(op[1]),
		.o_carry_in(cin));
	aas_top dut (.I_CORE_CLK(clk), .I_RST(rst), .I_CE(ce),
		.I_FIRST_OPERAND(a), .I_SECOND_OPERAND(b), .I_CARRY_IN(cin),
		.I_OP_SEL_LO(op[0]), .I_OP_SEL_HI(op[1]),
		.I_WIDTH_SEL_LO(wd[0]), .I_WIDTH_SEL_HI(wd[1]),
		.I_OPERAND_PASS_N(opn), .I_RESULT_PASS_N(rpn),
		.I_LOAD_FIRST_N(lan), .I_LOAD_SECOND_N(lbn),
		.I_RESULT_ZERO_N(zn), .I_BUS_DRIVE_N(bdn), .O_RESULT_BUS(bus),
		.O_RESULT_BUS_OE(oe), .O_CARRY_OUT(co), .O_OVERFLOW_FLAG(ov));
	// ****************************************
	// Checking helpers
	// ****************************************
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Returns {overflow, carry, sum}
	function automatic logic [17:0] ref_op(input logic [15:0] x,
		input logic [15:0] y, input logic [1:0] o, input logic [1:0] w);
		logic [15:0] p;
		logic [15:0] q;
		logic [16:0] r;
		logic [16:0] v;
		int s;
		s = 9 + 2 * w;
		p = x;
		q = y;
		for (int i = s + 1; i < 16; i++) begin
			p[i] = x[s];
			q[i] = y[s];
		end
		if (o == 2'b01) q = ~q;
		if (o == 2'b10) p = ~p;
		r = {1'b0, p} + {1'b0, q} + {16'h0000, o[0] ^ o[1]};
		// Signed overflow: the two top bits of the widened sum differ
		v = {p[15], p} + {q[15], q} + {16'h0000, o[0] ^ o[1]};
		return {v[16] != v[15], r};
	endfunction : ref_op
	task automatic comb(input logic [15:0] x, input logic [15:0] y,
		input logic [1:0] o, input logic [1:0] w);
		logic [17:0] r;
		@(negedge clk);
		a = x;
		b = y;
		op = o;
		wd = w;
		#1;
		r = ref_op(x, y, o, w);
		chk("sum", r[15:0], f_line);
		chk("carry", {15'h0000, r[16]}, {15'h0000, co});
		chk("overflow", {15'h0000, r[17]}, {15'h0000, ov});
	endtask : comb
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_comb;
		@(negedge clk);
		opn = 1'b0;
		rpn = 1'b0;
		comb(16'h7fff, 16'h0001, 2'b11, 2'b11);
		comb(16'h8000, 16'h0001, 2'b01, 2'b11);
		comb(16'h0003, 16'h0005, 2'b10, 2'b11);
		comb(16'hffff, 16'h0001, 2'b11, 2'b11);
		for (int i = 0; i < 4; i++) begin
			comb(16'h2a00, 16'h0a00, 2'b11, i[1:0]);
		end
		$display("test comb done");
	endtask : t_comb
	task automatic t_reg;
		@(negedge clk);
		opn = 1'b1;
		rpn = 1'b1;
		op = 2'b11;
		wd = 2'b11;
		a = 16'h1234;
		b = 16'h1111;
		lan = 1'b0;
		lbn = 1'b0;
		@(negedge clk);
		a = 16'hffff;
		b = 16'hffff;
		lan = 1'b1;
		lbn = 1'b1;
		@(negedge clk);
		chk("registered sum", 16'h2345, f_line);
		lan = 1'b0;
		a = 16'h0100;
		@(negedge clk);
		lan = 1'b1;
		@(negedge clk);
		chk("one operand loaded", 16'h1211, f_line);
		$display("test reg done");
	endtask : t_reg
	task automatic t_acc;
		@(negedge clk);
		opn = 1'b0;
		op = 2'b00;
		a = 16'h0007;
		zn = 1'b0;
		@(negedge clk);
		chk("cleared", 16'h0000, f_line);
		zn = 1'b1;
		repeat (3) @(negedge clk);
		chk("accumulated", 16'h0015, f_line);
		$display("test acc done");
	endtask : t_acc
	task automatic t_oe;
		@(negedge clk);
		bdn = 1'b1;
		#1;
		chk("floated", 16'hzzzz, f_line);
		@(negedge clk);
		bdn = 1'b0;
		#1;
		chk("driven", 16'h0001, {15'h0000, oe});
		$display("test oe done");
	endtask : t_oe
	task automatic t_freeze;
		@(negedge clk);
		zn = 1'b0;
		@(negedge clk);
		zn = 1'b1;
		ce = 1'b0;
		repeat (3) @(negedge clk);
		chk("frozen", 16'h0000, f_line);
		ce = 1'b1;
		@(negedge clk);
		chk("resumed", 16'h0007, f_line);
		$display("test freeze done");
	endtask : t_freeze
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_comb;
		t_reg;
		t_acc;
		t_oe;
		t_freeze;
		print_verdict;
	end
endmodule : aas_top_bench

`default_nettype wire
